// ===== sid_pkg.sv
/*
 Shared constants of the serial instruction decoder: op-codes, transfer
 lengths, field positions and reset values.
 Assumes it is compiled before every module that imports it.
*/
package sid_pkg;

    // Op-codes with the two ignored low bits cleared
    localparam logic [7:0] OP_NOP      = 8'h00;
    localparam logic [7:0] OP_MRESET   = 8'h04;
    localparam logic [7:0] OP_TXCTL_W  = 8'h08;
    localparam logic [7:0] OP_TXPUSH   = 8'h0C;
    localparam logic [7:0] OP_RX1CTL_W = 8'h10;
    localparam logic [7:0] OP_RX1LBL_W = 8'h14;
    localparam logic [7:0] OP_RX1PLF_W = 8'h18;
    localparam logic [7:0] OP_RX2CTL_W = 8'h24;
    localparam logic [7:0] OP_RX2LBL_W = 8'h28;
    localparam logic [7:0] OP_RX2PLF_W = 8'h2C;
    localparam logic [7:0] OP_FLAG_W   = 8'h34;
    localparam logic [7:0] OP_ADIV_W   = 8'h38;
    localparam logic [7:0] OP_TXSTART  = 8'h40;
    localparam logic [7:0] OP_SWRESET  = 8'h44;
    localparam logic [7:0] OP_RX1SET   = 8'h48;
    localparam logic [7:0] OP_RX2SET   = 8'h4C;
    localparam logic [7:0] OP_TXSTAT_R = 8'h80;
    localparam logic [7:0] OP_TXCTL_R  = 8'h84;
    localparam logic [7:0] OP_RX1STA_R = 8'h90;
    localparam logic [7:0] OP_RX1CTL_R = 8'h94;
    localparam logic [7:0] OP_RX1LBL_R = 8'h98;
    localparam logic [7:0] OP_RX1PLF_R = 8'h9C;
    localparam logic [7:0] OP_RX1POP   = 8'hA0;
    localparam logic [7:0] OP_RX1PL1_R = 8'hA4;
    localparam logic [7:0] OP_KEY_MASK = 8'hFC;

    // Serial framing
    localparam int         OP_BITS     = 8;
    localparam logic [8:0] CNT_OP_LAST = 9'h007;
    localparam logic [8:0] CNT_DATA0   = 9'h008;
    localparam logic [8:0] CNT_MAX     = 9'h1FF;
    localparam logic [8:0] CNT_LBL_END = 9'h108;
    localparam int         DIR_BIT     = 7;
    localparam int         TRANSMIT_MODE_SELECT_BIT   = 5;

    // Reset values and the label set-all value
    localparam logic [7:0]  CTL_RST  = 8'h00;
    localparam logic [23:0] PLF_RST  = 24'h00_0000;
    localparam logic [7:0]  LBL_RST  = 8'h00;
    localparam logic [7:0]  LBL_ALL  = 8'hFF;

endpackage

// ===== sid_lbl_mem.sv
/*
 Label acceptance memory for two receivers, 64 bytes of 8 labels each.
 Assumes byte writes and the serial read port run on the serial clock,
 the lookup port on the system clock; both read ports are registered.
*/
`timescale 1ns/1ps
module sid_lbl_mem
    import sid_pkg::*;
(
    input  wire logic       sclk_i,
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic       wr_en_i,
    input  wire logic [5:0] wr_addr_i,
    input  wire logic [7:0] wr_byte_i,
    input  wire logic       set_en_i,
    input  wire logic       set_rx2_i,
    input  wire logic       rd_en_i,
    input  wire logic [5:0] rd_addr_i,
    output logic      [7:0] rd_byte_o,
    input  wire logic       lk_rx2_i,
    input  wire logic [7:0] lk_label_i,
    output logic            lk_hit_o
);

    logic [7:0] mem_ff [64];
    logic [7:0] rd_ff;
    logic       hit_ff;

    always_ff @(posedge sclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            for (int i = 0; i < 64; i++)
                mem_ff[i] <= LBL_RST;
            rd_ff <= LBL_RST;
        end
        else
        begin
            for (int i = 0; i < 64; i++)
            begin
                if (set_en_i && ((i >= 32) == set_rx2_i))
                    mem_ff[i] <= LBL_ALL;
                else if (wr_en_i && (wr_addr_i == 6'(i)))
                    mem_ff[i] <= wr_byte_i;
            end
            if (rd_en_i)
                rd_ff <= mem_ff[rd_addr_i];
        end
    end

    // Highest label sits in bit 7 of byte 0
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            hit_ff <= 1'b0;
        else
            hit_ff <= mem_ff[{lk_rx2_i, ~lk_label_i[7:3]}][lk_label_i[2:0]];
    end

    assign rd_byte_o = rd_ff;
    assign lk_hit_o  = hit_ff;

endmodule

// ===== sid_decoder.sv
/*
 Serial instruction decoder: shifts op-codes and data on the serial clock,
 hands finished commands to the system clock, and serves reads.
 Assumes the host holds chip select low for a whole instruction, and that
 status inputs and the receive FIFO head are synchronous to mclk_i.
*/
`timescale 1ns/1ps

module sid_decoder
    import sid_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        si_i,
    output logic             so_o,
    input  wire logic        master_reset_pin_i,
    input  wire logic [7:0]  tx_status_i,
    input  wire logic [7:0]  rx1_status_i,
    input  wire logic [31:0] rx1_fifo_word_i,
    input  wire logic [23:0] rx1_pl1_word_i,
    input  wire logic        lbl_rx2_i,
    input  wire logic [7:0]  lbl_label_i,
    output logic             lbl_hit_o,
    output logic [7:0]       tx_ctrl_o,
    output logic [7:0]       rx1_ctrl_o,
    output logic [7:0]       rx2_ctrl_o,
    output logic [7:0]       flag_asgn_o,
    output logic [7:0]       aclk_div_o,
    output logic [23:0]      rx1_plf_o,
    output logic [23:0]      rx2_plf_o,
    output logic             tx_push_o,
    output logic [31:0]      tx_word_o,
    output logic             tx_start_o,
    output logic             rx1_pop_o,
    output logic             fifo_clear_o,
    output logic             master_reset_o
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic [8:0] data_bits(input logic [7:0] key);
        unique case (key)
            OP_TXCTL_W, OP_RX1CTL_W, OP_RX2CTL_W,
            OP_FLAG_W, OP_ADIV_W, OP_TXSTAT_R, OP_TXCTL_R,
            OP_RX1STA_R, OP_RX1CTL_R:              data_bits = 9'h008;
            OP_RX1PLF_W, OP_RX2PLF_W, OP_RX1PLF_R,
            OP_RX1PL1_R:                           data_bits = 9'h018;
            OP_TXPUSH, OP_RX1POP:                  data_bits = 9'h020;
            OP_RX1LBL_W, OP_RX2LBL_W, OP_RX1LBL_R: data_bits = 9'h100;
            default:                               data_bits = 9'h000;
        endcase
    endfunction

    // Commands that the system clock side must act on
    function automatic logic is_cmd(input logic [7:0] key);
        unique case (key)
            OP_MRESET, OP_TXCTL_W, OP_TXPUSH, OP_RX1CTL_W, OP_RX1PLF_W,
            OP_RX2CTL_W, OP_RX2PLF_W, OP_FLAG_W, OP_ADIV_W, OP_TXSTART,
            OP_SWRESET, OP_RX1POP: is_cmd = 1'b1;
            default:               is_cmd = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial clock side

    logic        spi_rst_n;
    logic [8:0]  cnt_ff,   nxt_cnt;
    logic [7:0]  op_ff,    nxt_op;
    logic [31:0] din_ff,   nxt_din;
    logic [31:0] osr_ff,   nxt_osr;
    logic        so_ff,    nxt_so;
    logic [7:0]  cmd_op_ff,   nxt_cmd_op;
    logic [31:0] cmd_data_ff, nxt_cmd_data;
    logic        cmd_tgl_ff,  nxt_cmd_tgl;
    logic [7:0]  op_now, key_now, key_ff;
    logic [31:0] din_now, rd_word;
    logic        commit, lbl_wr, lbl_set, lbl_rd_en;
    logic [5:0]  lbl_wr_addr, lbl_rd_addr;
    logic [7:0]  lbl_rd_byte;
    logic [7:0]  tx_ctrl_ff, rx1_ctrl_ff, rx2_ctrl_ff, flag_ff, adiv_ff;
    logic [23:0] rx1_plf_ff, rx2_plf_ff;
    logic [7:0]  txs_img_ff, rx1s_img_ff;
    logic [31:0] fifo_img_ff;
    logic [23:0] pl1_img_ff;

    // Raised chip select clears the frame state at once
    assign spi_rst_n = nrst_i & ~cs_n_i;

    always_comb
    begin
        op_now  = (cnt_ff == CNT_OP_LAST) ? {op_ff[6:0], si_i} : op_ff;
        key_now = op_now & OP_KEY_MASK;
        key_ff  = op_ff & OP_KEY_MASK;
        din_now = {din_ff[30:0], si_i};
        // Read images hold still while the frame runs
        unique case (key_now)
            OP_TXSTAT_R: rd_word = {txs_img_ff, 24'h00_0000};
            OP_TXCTL_R:  rd_word = {tx_ctrl_ff, 24'h00_0000};
            OP_RX1STA_R: rd_word = {rx1s_img_ff, 24'h00_0000};
            OP_RX1CTL_R: rd_word = {rx1_ctrl_ff, 24'h00_0000};
            OP_RX1PLF_R: rd_word = {rx1_plf_ff, 8'h00};
            OP_RX1POP:   rd_word = fifo_img_ff;
            OP_RX1PL1_R: rd_word = {pl1_img_ff, 8'h00};
            default:     rd_word = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        nxt_cnt = (cnt_ff == CNT_MAX) ? cnt_ff : cnt_ff + 9'h001;
        nxt_op  = (cnt_ff < CNT_DATA0) ? {op_ff[6:0], si_i} : op_ff;
        nxt_din = (cnt_ff >= CNT_DATA0) ? din_now : din_ff;
        if (cnt_ff == CNT_OP_LAST)
            nxt_osr = rd_word;
        else
            nxt_osr = {osr_ff[30:0], 1'b0};
        // Commit only on the edge that brings the final data bit, or the final op-code bit for commands without data
        commit = is_cmd(key_now) && op_now[DIR_BIT] == 1'b0
                 ? (cnt_ff == CNT_OP_LAST + data_bits(key_now))
                 : (key_now == OP_RX1POP) &&
                   (cnt_ff == CNT_OP_LAST + data_bits(key_now));
        nxt_cmd_op   = commit ? key_now : cmd_op_ff;
        nxt_cmd_data = commit ? din_now : cmd_data_ff;
        nxt_cmd_tgl  = commit ? ~cmd_tgl_ff : cmd_tgl_ff;
        // Byte k of the label stream lands in memory byte k, or 32 + k for receiver 2
        lbl_wr = ((key_ff == OP_RX1LBL_W) || (key_ff == OP_RX2LBL_W)) &&
                 (cnt_ff >= CNT_DATA0) && (cnt_ff < CNT_LBL_END) &&
                 (cnt_ff[2:0] == 3'h7);
        lbl_wr_addr = {key_ff == OP_RX2LBL_W, 5'(cnt_ff[7:3] - 5'h01)};
        lbl_set = (cnt_ff == CNT_OP_LAST) &&
                  ((key_now == OP_RX1SET) || (key_now == OP_RX2SET));
        lbl_rd_en   = (cnt_ff[2:0] == 3'h7);
        lbl_rd_addr = {1'b0, cnt_ff[7:3]};
        if ((key_ff == OP_RX1LBL_R) && (cnt_ff >= CNT_DATA0))
            nxt_so = lbl_rd_byte[~cnt_ff[2:0]];
        else
            nxt_so = osr_ff[31];
    end

    always_ff @(posedge sclk_i or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
        begin
            cnt_ff <= 9'h000;
            op_ff  <= 8'h00;
            din_ff <= 32'h0000_0000;
            osr_ff <= 32'h0000_0000;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            op_ff  <= nxt_op;
            din_ff <= nxt_din;
            osr_ff <= nxt_osr;
        end
    end

    always_ff @(negedge sclk_i or negedge spi_rst_n)
    begin
        if (!spi_rst_n)
            so_ff <= 1'b0;
        else
            so_ff <= nxt_so;
    end

    // Held until the next command so the other side reads it settled
    always_ff @(posedge sclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cmd_op_ff   <= OP_NOP;
            cmd_data_ff <= 32'h0000_0000;
            cmd_tgl_ff  <= 1'b0;
        end
        else
        begin
            cmd_op_ff   <= nxt_cmd_op;
            cmd_data_ff <= nxt_cmd_data;
            cmd_tgl_ff  <= nxt_cmd_tgl;
        end
    end

    assign so_o = so_ff;

    sid_lbl_mem u_lbl_mem (
        .sclk_i     (sclk_i),
        .mclk_i     (mclk_i),
        .nrst_i     (nrst_i),
        .wr_en_i    (lbl_wr),
        .wr_addr_i  (lbl_wr_addr),
        .wr_byte_i  (din_now[7:0]),
        .set_en_i   (lbl_set),
        .set_rx2_i  (key_now == OP_RX2SET),
        .rd_en_i    (lbl_rd_en),
        .rd_addr_i  (lbl_rd_addr),
        .rd_byte_o  (lbl_rd_byte),
        .lk_rx2_i   (lbl_rx2_i),
        .lk_label_i (lbl_label_i),
        .lk_hit_o   (lbl_hit_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // System clock side

    logic [2:0] tgl_sync_ff;
    logic [1:0] cs_sync_ff, mr_sync_ff;
    logic       cmd_new, mr_any;
    logic [7:0] nxt_tx_ctrl, nxt_rx1_ctrl, nxt_rx2_ctrl, nxt_flag, nxt_adiv;
    logic [23:0] nxt_rx1_plf, nxt_rx2_plf;
    logic       push_ff, start_ff, pop_ff, clr_ff, mrst_ff;
    logic       nxt_push, nxt_start, nxt_pop, nxt_clr, nxt_mrst;
    logic [31:0] word_ff, nxt_word;

    // Third stage only feeds the toggle edge detector
    assign cmd_new = tgl_sync_ff[2] ^ tgl_sync_ff[1];
    assign mr_any  = mr_sync_ff[1] | (cmd_new && cmd_op_ff == OP_MRESET);

    always_comb
    begin
        nxt_tx_ctrl  = tx_ctrl_ff;
        nxt_rx1_ctrl = rx1_ctrl_ff;
        nxt_rx2_ctrl = rx2_ctrl_ff;
        nxt_flag     = flag_ff;
        nxt_adiv     = adiv_ff;
        nxt_rx1_plf  = rx1_plf_ff;
        nxt_rx2_plf  = rx2_plf_ff;
        nxt_word     = word_ff;
        nxt_push     = 1'b0;
        nxt_start    = 1'b0;
        nxt_pop      = 1'b0;
        nxt_clr      = 1'b0;
        nxt_mrst     = mr_any;
        if (mr_any)
        begin
            nxt_tx_ctrl  = CTL_RST;
            nxt_rx1_ctrl = CTL_RST;
            nxt_rx2_ctrl = CTL_RST;
            nxt_flag     = CTL_RST;
            nxt_adiv     = CTL_RST;
            nxt_rx1_plf  = PLF_RST;
            nxt_rx2_plf  = PLF_RST;
        end
        else if (cmd_new)
        begin
            unique case (cmd_op_ff)
                OP_TXCTL_W:  nxt_tx_ctrl  = cmd_data_ff[7:0];
                OP_RX1CTL_W: nxt_rx1_ctrl = cmd_data_ff[7:0];
                OP_RX2CTL_W: nxt_rx2_ctrl = cmd_data_ff[7:0];
                OP_FLAG_W:   nxt_flag     = cmd_data_ff[7:0];
                OP_ADIV_W:   nxt_adiv     = cmd_data_ff[7:0];
                OP_RX1PLF_W: nxt_rx1_plf  = cmd_data_ff[23:0];
                OP_RX2PLF_W: nxt_rx2_plf  = cmd_data_ff[23:0];
                OP_TXPUSH:
                begin
                    nxt_push = 1'b1;
                    nxt_word = cmd_data_ff;
                end
                OP_TXSTART:  nxt_start = ~tx_ctrl_ff[TRANSMIT_MODE_SELECT_BIT];
                OP_SWRESET:  nxt_clr   = 1'b1;
                OP_RX1POP:   nxt_pop   = 1'b1;
                default:     ;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tgl_sync_ff <= 3'h0;
            cs_sync_ff  <= 2'h3;
            mr_sync_ff  <= 2'h0;
            tx_ctrl_ff  <= CTL_RST;
            rx1_ctrl_ff <= CTL_RST;
            rx2_ctrl_ff <= CTL_RST;
            flag_ff     <= CTL_RST;
            adiv_ff     <= CTL_RST;
            rx1_plf_ff  <= PLF_RST;
            rx2_plf_ff  <= PLF_RST;
            word_ff     <= 32'h0000_0000;
            push_ff     <= 1'b0;
            start_ff    <= 1'b0;
            pop_ff      <= 1'b0;
            clr_ff      <= 1'b0;
            mrst_ff     <= 1'b0;
            txs_img_ff  <= 8'h00;
            rx1s_img_ff <= 8'h00;
            fifo_img_ff <= 32'h0000_0000;
            pl1_img_ff  <= 24'h00_0000;
        end
        else
        begin
            tgl_sync_ff <= {tgl_sync_ff[1:0], cmd_tgl_ff};
            cs_sync_ff  <= {cs_sync_ff[0], cs_n_i};
            mr_sync_ff  <= {mr_sync_ff[0], master_reset_pin_i};
            tx_ctrl_ff  <= nxt_tx_ctrl;
            rx1_ctrl_ff <= nxt_rx1_ctrl;
            rx2_ctrl_ff <= nxt_rx2_ctrl;
            flag_ff     <= nxt_flag;
            adiv_ff     <= nxt_adiv;
            rx1_plf_ff  <= nxt_rx1_plf;
            rx2_plf_ff  <= nxt_rx2_plf;
            word_ff     <= nxt_word;
            push_ff     <= nxt_push;
            start_ff    <= nxt_start;
            pop_ff      <= nxt_pop;
            clr_ff      <= nxt_clr;
            mrst_ff     <= nxt_mrst;
            // Refresh only while deselected; frozen images cross safely
            if (cs_sync_ff[1])
            begin
                txs_img_ff  <= tx_status_i;
                rx1s_img_ff <= rx1_status_i;
                fifo_img_ff <= rx1_fifo_word_i;
                pl1_img_ff  <= rx1_pl1_word_i;
            end
        end
    end

    assign tx_ctrl_o      = tx_ctrl_ff;
    assign rx1_ctrl_o     = rx1_ctrl_ff;
    assign rx2_ctrl_o     = rx2_ctrl_ff;
    assign flag_asgn_o    = flag_ff;
    assign aclk_div_o     = adiv_ff;
    assign rx1_plf_o      = rx1_plf_ff;
    assign rx2_plf_o      = rx2_plf_ff;
    assign tx_push_o      = push_ff;
    assign tx_word_o      = word_ff;
    assign tx_start_o     = start_ff;
    assign rx1_pop_o      = pop_ff;
    assign fifo_clear_o   = clr_ff;
    assign master_reset_o = mrst_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    op_shift_a: assert property (@(posedge sclk_i) disable iff (!spi_rst_n)
        (cnt_ff < CNT_DATA0) |=> (op_ff[0] == $past(si_i)))
        else $error("op-code bit not shifted in");

    read_out_a: assert property (@(posedge sclk_i) disable iff (!spi_rst_n)
        (cnt_ff > CNT_DATA0 && key_ff != OP_RX1LBL_R) |-> (so_o == osr_ff[31]))
        else $error("serial output not tracking read word");

    push_word_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (cmd_new && cmd_op_ff == OP_TXPUSH && !mr_any)
        |=> (tx_push_o && tx_word_o == $past(cmd_data_ff)) ##1 !tx_push_o)
        else $error("transmit push wrong");

    ctrl_load_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (cmd_new && cmd_op_ff == OP_RX1CTL_W && !mr_any)
        |=> (rx1_ctrl_o == $past(cmd_data_ff[7:0])))
        else $error("receiver 1 control not loaded");

    start_gate_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (cmd_new && cmd_op_ff == OP_TXSTART && !mr_any)
        |=> (tx_start_o == !$past(tx_ctrl_ff[TRANSMIT_MODE_SELECT_BIT])))
        else $error("transmit start ignores mode bit");

    clear_pulse_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (cmd_new && cmd_op_ff == OP_SWRESET && !mr_any)
        |=> fifo_clear_o ##1 !fifo_clear_o)
        else $error("FIFO clear not one pulse");

    mreset_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (cmd_new && cmd_op_ff == OP_MRESET)
        |=> (master_reset_o && tx_ctrl_o == CTL_RST && rx1_plf_o == PLF_RST))
        else $error("software master reset not applied");

    nop_keep_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (!cmd_new && !mr_any)
        |=> ($stable(tx_ctrl_o) && $stable(rx1_plf_o) && !tx_push_o && !rx1_pop_o))
        else $error("state changed without a command");

    partial_drop_a: assert property (@(posedge sclk_i) disable iff (!nrst_i)
        (cmd_tgl_ff != $past(cmd_tgl_ff))
        |-> ($past(cnt_ff) == CNT_OP_LAST + data_bits($past(key_now))))
        else $error("command committed before its last bit");

endmodule

// ===== sid_host.sv
/*
 SPI host model: one instruction per frame, serial clock only inside frames.
 Assumes the caller runs one frame at a time.
*/
`timescale 1ns/1ps
module sid_host (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // Op-code then data in the low n bits, MSB first
    task automatic xfer(input logic [263:0] bits, input int n, output logic [255:0] rd);
        rd = '0;
        cs_n_o = 1'b0;
        #40;
        for (int i = 0; i < n; i++)
        begin
            si_o = bits[n-1-i];
            #80 sclk_o = 1'b1;
            if (i >= 8)
                rd = {rd[254:0], so_i};
            #80 sclk_o = 1'b0;
        end
        #40 cs_n_o = 1'b1;
        // Pull-down level once released; gap lets the command land
        si_o = 1'b0;
        #1000;
    endtask
endmodule

// ===== tb_top.sv
/*
 Self-checking bench of the instruction decoder.
 Assumes sid_pkg, the design and the host model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
    import sid_pkg::*;
    logic mclk_i = 1'b0, nrst_i = 1'b0, sclk, cs_n, si, so, lbl_rx2_i = 1'b0, hit;
    logic mr_pin = 1'b0;
    logic [7:0] tx_status_i = 8'h00, rx1_status_i = 8'h00, lbl_label_i = 8'h00;
    logic [31:0] rx1_fifo_word_i = 32'h0000_0000;
    logic [23:0] rx1_pl1_word_i = 24'h00_0000;
    logic [7:0] tx_ctrl, rx1_ctrl, rx2_ctrl, flag, adiv;
    logic [23:0] plf1, plf2;
    logic [31:0] tx_word;
    logic push, start, pop, clr, mr;
    logic [255:0] rd;
    int failures = 0, n_checks = 0, n_push = 0, n_start = 0, n_pop = 0, n_clr = 0, n_mr = 0;

    always #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
    begin
        n_push  += (push === 1'b1);
        n_start += (start === 1'b1);
        n_pop   += (pop === 1'b1);
        n_clr   += (clr === 1'b1);
        n_mr    += (mr === 1'b1);
    end

    sid_host host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
    sid_decoder dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .si_i(si), .so_o(so), .master_reset_pin_i(mr_pin), .tx_status_i(tx_status_i),
        .rx1_status_i(rx1_status_i), .rx1_fifo_word_i(rx1_fifo_word_i),
        .rx1_pl1_word_i(rx1_pl1_word_i), .lbl_rx2_i(lbl_rx2_i), .lbl_label_i(lbl_label_i),
        .lbl_hit_o(hit), .tx_ctrl_o(tx_ctrl), .rx1_ctrl_o(rx1_ctrl), .rx2_ctrl_o(rx2_ctrl),
        .flag_asgn_o(flag), .aclk_div_o(adiv), .rx1_plf_o(plf1), .rx2_plf_o(plf2),
        .tx_push_o(push), .tx_word_o(tx_word), .tx_start_o(start), .rx1_pop_o(pop),
        .fifo_clear_o(clr), .master_reset_o(mr));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input int nb, input logic [255:0] d);
        host.xfer(({256'h0, op} << nb) | {8'h00, d}, nb + 8, rd);
    endtask

    task automatic look(input logic rx2, input logic [7:0] lbl, input logic exp);
        @(posedge mclk_i);
        lbl_rx2_i   <= rx2;
        lbl_label_i <= lbl;
        repeat (3) @(posedge mclk_i);
        chk(hit, exp, "label lookup");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] ops [5] = '{OP_TXCTL_W, OP_RX1CTL_W, OP_RX2CTL_W, OP_FLAG_W, OP_ADIV_W};
        for (int i = 0; i < 5; i++)
            cmd(ops[i], 8, 8'h5A ^ i);
        chk(tx_ctrl, 8'h5A, "tx control");
        chk(rx1_ctrl, 8'h5B, "rx1 control");
        chk(rx2_ctrl, 8'h58, "rx2 control");
        chk(flag, 8'h59, "flag assignment");
        chk(adiv, 8'h5E, "clock division");
        cmd(OP_TXCTL_R, 8, 0);
        chk(rd[7:0], 8'h5A, "tx control read");
        cmd(OP_RX1CTL_R, 8, 0);
        chk(rd[7:0], 8'h5B, "rx1 control read");
        $display("register writes done");
    endtask

    task automatic t_push;
        int p = n_push;
        cmd(OP_TXPUSH, 32, 32'h8123_4567);
        chk(n_push - p, 1, "push count");
        chk(tx_word, 32'h8123_4567, "pushed word");
        cmd(OP_TXPUSH, 24, 24'hFF_FFFF);
        chk(n_push - p, 1, "short push committed");
        chk(tx_word, 32'h8123_4567, "short push changed word");
        cmd(8'h3C, 8, 8'hFF);
        cmd(OP_NOP, 0, 0);
        chk(tx_ctrl, 8'h5A, "unknown op changed state");
        chk(n_push - p + n_start + n_clr + n_mr, 1, "no-op pulsed");
        $display("push and no-op done");
    endtask

    task automatic t_plf;
        cmd(OP_RX1PLF_W, 24, 24'h11_2233);
        chk(plf1, 24'h11_2233, "rx1 filters");
        cmd(OP_RX2PLF_W, 24, 24'h44_5566);
        chk(plf2, 24'h44_5566, "rx2 filters");
        cmd(OP_RX1PLF_R, 24, 0);
        chk(rd[23:0], 24'h11_2233, "filter read");
        $display("filters done");
    endtask

    task automatic t_lbl;
        cmd(OP_RX1LBL_W, 256, {8'hB2, 248'h0});
        for (int l = 8'hF8; l <= 8'hFF; l++)
            look(1'b0, 8'(l), 1'((8'hB2 >> (l - 8'hF8)) & 1));
        look(1'b0, 8'h00, 1'b0);
        cmd(OP_RX1LBL_R, 256, 0);
        chk(rd[255:224], 32'hB200_0000, "label read");
        cmd(OP_RX2SET, 0, 0);
        look(1'b1, 8'h00, 1'b1);
        look(1'b0, 8'h00, 1'b0);
        cmd(OP_RX1SET, 0, 0);
        look(1'b0, 8'hFE, 1'b1);
        cmd(OP_RX2LBL_W, 256, {8'h80, 248'h0});
        look(1'b1, 8'hFF, 1'b1);
        look(1'b1, 8'hFE, 1'b0);
        look(1'b1, 8'h00, 1'b0);
        look(1'b0, 8'h00, 1'b1);
        $display("label memory done");
    endtask

    task automatic t_ctl;
        int s = n_start;
        int c = n_clr;
        int m = n_mr;
        cmd(OP_TXCTL_W | 8'h03, 8, 8'h20);
        cmd(OP_TXSTART, 0, 0);
        chk(n_start - s, 0, "start with mode bit set");
        cmd(OP_TXCTL_W, 8, 8'h00);
        cmd(OP_TXSTART, 0, 0);
        chk(n_start - s, 1, "start with mode bit clear");
        cmd(OP_SWRESET, 0, 0);
        chk(n_clr - c, 1, "fifo clear");
        cmd(OP_MRESET, 0, 0);
        chk(n_mr - m, 1, "master reset pulse");
        chk(rx1_ctrl, 8'h00, "control after master reset");
        cmd(OP_RX1CTL_W, 8, 8'h77);
        @(posedge mclk_i);
        mr_pin <= 1'b1;
        repeat (2) @(posedge mclk_i);
        mr_pin <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk(n_mr - m, 3, "pin master reset pulse");
        chk(rx1_ctrl, 8'h00, "control after pin reset");
        $display("control commands done");
    endtask

    task automatic t_rd;
        int p = n_pop;
        @(posedge mclk_i);
        tx_status_i     <= 8'hC3;
        rx1_status_i    <= 8'h3C;
        rx1_fifo_word_i <= 32'hDEAD_BEEF;
        rx1_pl1_word_i  <= 24'hAB_CDEF;
        repeat (10) @(posedge mclk_i);
        cmd(OP_TXSTAT_R, 8, 0);
        chk(rd[7:0], 8'hC3, "tx status read");
        cmd(OP_RX1STA_R, 8, 0);
        chk(rd[7:0], 8'h3C, "rx1 status read");
        cmd(OP_RX1POP, 32, 0);
        chk(rd[31:0], 32'hDEAD_BEEF, "fifo word read");
        chk(n_pop - p, 1, "fifo pop");
        cmd(OP_RX1PL1_R, 24, 0);
        chk(rd[23:0], 24'hAB_CDEF, "priority data read");
        $display("reads done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #2_000_000;
        failures++;
        complete_run();
    end

    initial
    begin
        repeat (8) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        t_regs();
        t_push();
        t_plf();
        t_lbl();
        t_ctl();
        t_rd();
        complete_run();
    end
endmodule
